/* File: design/timer_flags_defines.vh */
// register offsets, field positions and reset values of the timer event-flag block
`ifndef TIMER_FLAGS_DEFINES_VH
`define TIMER_FLAGS_DEFINES_VH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define OFS_STATUS 8'h00
`define OFS_MODULO 8'h04
`define OFS_COUNT 8'h08
`define OFS_CH_BASE 8'h10

// ----------------------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------------------
`define ST_OVF_IE_BIT 0
`define ST_CENTER_BIT 1
`define ST_OVF_FLAG_BIT 7

// ----------------------------------------------------------------------------
// channel control register fields
// ----------------------------------------------------------------------------
`define CH_ELS_LOW_BIT 0
`define CH_ELS_HIGH_BIT 1
`define CH_MS_LOW_BIT 2
`define CH_MS_HIGH_BIT 3
`define CH_IE_BIT 4
`define CH_FLAG_BIT 7
`define CH_CFG_W 5

// ----------------------------------------------------------------------------
// reset values and counter constants
// ----------------------------------------------------------------------------
`define RST_CFG 5'h00
`define RST_VALUE 16'h0000
`define RST_MODULO 16'h0000
`define FREE_RUN_TERM 16'hffff
`define COUNT_ZERO 16'h0000

`endif

/* File: design/channel_event.v */
// one timer channel: mode decode, capture edge detect, event flag and its request
`timescale 1ns/1ps
`default_nettype none

module channel_event (
   // clock and reset
   input wire core_clk,
   input wire rst,
   // configuration
   input wire center_align_select,
   input wire [4:0] cfg,
   input wire [15:0] chan_value,
   // counter view
   input wire [15:0] cnt_value,
   input wire cnt_changed,
   // capture pin, asynchronous
   input wire capture_in,
   // software access strobes
   input wire flag_read,
   input wire flag_write,
   input wire flag_wdata,
   // results
   output wire channel_event_flag,
   output wire channel_irq
);

`include "timer_flags_defines.vh"

   reg sync1_q;
   reg sync2_q;
   reg sync3_q;
   reg flag_q;
   reg flag_d;
   reg armed_q;
   reg armed_d;
   reg event_hit;

   wire edge_select_low = cfg[`CH_ELS_LOW_BIT];
   wire edge_select_high = cfg[`CH_ELS_HIGH_BIT];
   wire [1:0] mode_sel = {cfg[`CH_MS_HIGH_BIT], cfg[`CH_MS_LOW_BIT]};
   wire rise = sync2_q & ~sync3_q;
   wire fall = ~sync2_q & sync3_q;
   wire match = cnt_changed & (cnt_value == chan_value);

   // ----------------------------------------------------------------------------
   // capture synchroniser; edges are taken only from the settled stages
   // ----------------------------------------------------------------------------
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         sync3_q <= 1'b0;
      end else begin
         sync1_q <= capture_in;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
      end
   end

   // ----------------------------------------------------------------------------
   // event source by mode
   // ----------------------------------------------------------------------------
   always @* begin
      event_hit = 1'b0;
      if (center_align_select) begin
         // a match on the way up and on the way down both flag
         event_hit = match;
      end else begin
         case (mode_sel)
            2'b00: begin
               event_hit = (edge_select_low & rise) | (edge_select_high & fall);
            end
            2'b01: begin
               event_hit = match;
            end
            default: begin
               event_hit = match;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------------
   // flag with read-then-write-zero clearing; a new event restarts the sequence
   // ----------------------------------------------------------------------------
   always @* begin
      flag_d = flag_q;
      armed_d = armed_q;
      if (event_hit) begin
         flag_d = 1'b1;
         armed_d = 1'b0;
      end else begin
         if (flag_write) begin
            armed_d = 1'b0;
            if (armed_q && !flag_wdata) begin
               flag_d = 1'b0;
            end
         end else if (flag_read && flag_q) begin
            armed_d = 1'b1;
         end
      end
   end

   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         flag_q <= 1'b0;
         armed_q <= 1'b0;
      end else begin
         flag_q <= flag_d;
         armed_q <= armed_d;
      end
   end

   assign channel_event_flag = flag_q;
   assign channel_irq = flag_q & cfg[`CH_IE_BIT];

endmodule

`default_nettype wire

/* File: design/timer_pwm_event_flags.v */
// event-flag and interrupt-request logic of a 16-bit timer, with its AHB-Lite registers
`timescale 1ns/1ps
`default_nettype none

//
// Functional notes
// - each source sets its flag on its event; software can poll the flag.
// - interrupt request is high while flag is one and its enable is set.
// - flag clears only after a read seeing one, then a write of zero.
// - an event between the read and the write restarts it; flag stays set.
// - edge mode: overflow flag on wrap from terminal count (or 0xffff) to zero.
// - center mode: overflow flag when counting turns from up to down.
// - capture channel flags on the edge chosen by the two edge-select bits; in center mode it flags on a counter match instead.
// - output-compare channel flags each time counter equals its value.
// - edge PWM channel flags when counter equals value, end of duty.
// - center PWM channel flags on both matches, start and end of duty.
// - interrupt requests are active-high; vectors are the integrator's business.
// - reset clears control: overflow enable off, every channel input capture.
module timer_pwm_event_flags #(
   parameter NUM_CH = 1
) (
   // clock and reset
   input wire core_clk,
   input wire rst,
   // ahb-lite slave
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire hreadyout,
   output wire hresp,
   output reg [31:0] hrdata,
   // counter datapath view
   input wire [15:0] cnt_value,
   input wire cnt_down,
   // capture pins
   input wire [NUM_CH-1:0] capture_in,
   // configuration towards the counter datapath
   output wire center_align_select,
   output wire [15:0] modulo_value,
   // interrupt requests
   output wire overflow_irq,
   output wire [NUM_CH-1:0] channel_irq
);

`include "timer_flags_defines.vh"

   // ----------------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------------
   reg ovf_ie_q;
   reg center_q;
   reg [15:0] modulo_q;
   reg [NUM_CH*5-1:0] ch_cfg_q;
   reg [NUM_CH*16-1:0] ch_val_q;
   reg [15:0] cnt_q;
   reg cnt_down_q;
   reg ovf_flag_q;
   reg ovf_flag_d;
   reg ovf_armed_q;
   reg ovf_armed_d;
   reg wr_q;
   reg [7:0] waddr_q;
   reg [31:0] rdata_d;
   integer i;

   wire [NUM_CH-1:0] ch_flag;
   reg [NUM_CH-1:0] ch_read;
   reg [NUM_CH-1:0] ch_write;

   // ----------------------------------------------------------------------------
   // bus decode; zero wait states, so the slave is always ready
   // ----------------------------------------------------------------------------
   wire accept = hsel & hready & htrans[1];
   wire rd_acc = accept & ~hwrite;
   wire wr_acc = accept & hwrite;
   wire [7:0] raddr = haddr[7:0];
   wire hi_zero = (haddr[31:8] == 24'h000000);

   wire [7:0] r_off = raddr - `OFS_CH_BASE;
   wire [4:0] r_idx = r_off[7:3];
   wire r_in_ch = hi_zero & (raddr >= `OFS_CH_BASE) & ({27'd0, r_idx} < NUM_CH) &
      (raddr[1:0] == 2'b00);
   wire r_is_val = r_off[2];

   wire [7:0] w_off = waddr_q - `OFS_CH_BASE;
   wire [4:0] w_idx = w_off[7:3];
   wire w_in_ch = (waddr_q >= `OFS_CH_BASE) & ({27'd0, w_idx} < NUM_CH) &
      (waddr_q[1:0] == 2'b00);
   wire w_is_val = w_off[2];

   wire rd_status = rd_acc & hi_zero & (raddr == `OFS_STATUS);
   wire wr_status = wr_q & (waddr_q == `OFS_STATUS);
   wire wr_modulo = wr_q & (waddr_q == `OFS_MODULO);

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // a write address outside the low page is remembered as an unmapped offset
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         wr_q <= 1'b0;
         waddr_q <= 8'h00;
      end else begin
         wr_q <= wr_acc;
         if (wr_acc) begin
            waddr_q <= hi_zero ? raddr : 8'hff;
         end
      end
   end

   // ----------------------------------------------------------------------------
   // per-channel read and write strobes of the control register
   // ----------------------------------------------------------------------------
   always @* begin
      ch_read = {NUM_CH{1'b0}};
      ch_write = {NUM_CH{1'b0}};
      for (i = 0; i < NUM_CH; i = i + 1) begin
         if (rd_acc && r_in_ch && !r_is_val && (r_idx == i[4:0])) begin
            ch_read[i] = 1'b1;
         end
         if (wr_q && w_in_ch && !w_is_val && (w_idx == i[4:0])) begin
            ch_write[i] = 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------------------
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ovf_ie_q <= 1'b0;
         center_q <= 1'b0;
         modulo_q <= `RST_MODULO;
         ch_cfg_q <= {NUM_CH{`RST_CFG}};
         ch_val_q <= {NUM_CH{`RST_VALUE}};
      end else begin
         if (wr_status) begin
            ovf_ie_q <= hwdata[`ST_OVF_IE_BIT];
            center_q <= hwdata[`ST_CENTER_BIT];
         end
         if (wr_modulo) begin
            modulo_q <= hwdata[15:0];
         end
         for (i = 0; i < NUM_CH; i = i + 1) begin
            if (ch_write[i]) begin
               ch_cfg_q[i*5 +: 5] <= hwdata[4:0];
            end
            if (wr_q && w_in_ch && w_is_val && (w_idx == i[4:0])) begin
               ch_val_q[i*16 +: 16] <= hwdata[15:0];
            end
         end
      end
   end

   assign center_align_select = center_q;
   assign modulo_value = modulo_q;

   // ----------------------------------------------------------------------------
   // counter observation: events fire on the cycle the count moves
   // ----------------------------------------------------------------------------
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cnt_q <= `COUNT_ZERO;
         cnt_down_q <= 1'b0;
      end else begin
         cnt_q <= cnt_value;
         cnt_down_q <= cnt_down;
      end
   end

   wire cnt_changed = (cnt_value != cnt_q);
   // a zero modulo means the counter runs free through 0xffff
   wire [15:0] term = (modulo_q == `COUNT_ZERO) ? `FREE_RUN_TERM : modulo_q;
   wire wrap_hit = cnt_changed & (cnt_q == term) & (cnt_value == `COUNT_ZERO);
   wire turn_hit = ~cnt_down_q & cnt_down & (cnt_q == modulo_q);
   wire ovf_event = center_q ? turn_hit : wrap_hit;

   // ----------------------------------------------------------------------------
   // overflow flag with the two-step clear
   // ----------------------------------------------------------------------------
   always @* begin
      ovf_flag_d = ovf_flag_q;
      ovf_armed_d = ovf_armed_q;
      if (ovf_event) begin
         ovf_flag_d = 1'b1;
         ovf_armed_d = 1'b0;
      end else begin
         if (wr_status) begin
            ovf_armed_d = 1'b0;
            if (ovf_armed_q && !hwdata[`ST_OVF_FLAG_BIT]) begin
               ovf_flag_d = 1'b0;
            end
         end else if (rd_status && ovf_flag_q) begin
            ovf_armed_d = 1'b1;
         end
      end
   end

   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ovf_flag_q <= 1'b0;
         ovf_armed_q <= 1'b0;
      end else begin
         ovf_flag_q <= ovf_flag_d;
         ovf_armed_q <= ovf_armed_d;
      end
   end

   // active-high level request, gated by its enable
   assign overflow_irq = ovf_flag_q & ovf_ie_q;

   // ----------------------------------------------------------------------------
   // channels
   // ----------------------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < NUM_CH; g = g + 1) begin : ch
         channel_event u_chan (
            .core_clk(core_clk),
            .rst(rst),
            .center_align_select(center_q),
            .cfg(ch_cfg_q[g*5 +: 5]),
            .chan_value(ch_val_q[g*16 +: 16]),
            .cnt_value(cnt_value),
            .cnt_changed(cnt_changed),
            .capture_in(capture_in[g]),
            .flag_read(ch_read[g]),
            .flag_write(ch_write[g]),
            .flag_wdata(hwdata[`CH_FLAG_BIT]),
            .channel_event_flag(ch_flag[g]),
            .channel_irq(channel_irq[g])
         );
      end
   endgenerate

   // ----------------------------------------------------------------------------
   // read data, captured at the address phase so it stands through the data phase
   // ----------------------------------------------------------------------------
   always @* begin
      rdata_d = 32'h00000000;
      if (hi_zero && raddr == `OFS_STATUS) begin
         rdata_d[`ST_OVF_IE_BIT] = ovf_ie_q;
         rdata_d[`ST_CENTER_BIT] = center_q;
         rdata_d[`ST_OVF_FLAG_BIT] = ovf_flag_q;
      end else if (hi_zero && raddr == `OFS_MODULO) begin
         rdata_d[15:0] = modulo_q;
      end else if (hi_zero && raddr == `OFS_COUNT) begin
         rdata_d[15:0] = cnt_value;
      end else if (r_in_ch) begin
         for (i = 0; i < NUM_CH; i = i + 1) begin
            if (r_idx == i[4:0]) begin
               if (r_is_val) begin
                  rdata_d[15:0] = ch_val_q[i*16 +: 16];
               end else begin
                  rdata_d[4:0] = ch_cfg_q[i*5 +: 5];
                  rdata_d[`CH_FLAG_BIT] = ch_flag[i];
               end
            end
         end
      end
   end

   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         hrdata <= 32'h00000000;
      end else if (rd_acc) begin
         hrdata <= rdata_d;
      end
   end

endmodule

`default_nettype wire

/* File: testbench/timer_flags_chk.sv */
// assertion checker for the timer event-flag block
`timescale 1ns/1ps
`default_nettype none

module timer_flags_chk #(
   parameter NUM_CH = 1
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // bus
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   // timer side
   input wire logic [15:0] cnt_value,
   input wire logic cnt_down,
   input wire logic center_align_select,
   input wire logic [15:0] modulo_value,
   input wire logic overflow_irq,
   input wire logic [NUM_CH-1:0] channel_irq
);
   logic wr_q;
   logic ovf_ie_q;
   logic ch_ie_q;
   logic [31:0] adr_q;
   logic [15:0] cnt_q;
   wire logic ovf_ev;

   // ---------------------------------------------
   // shadow of the enables, tracked from writes
   // ---------------------------------------------
   assign ovf_ev = !center_align_select && cnt_value == 16'h0000 &&
      cnt_q == ((modulo_value == 16'h0000) ? 16'hffff : modulo_value);
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         wr_q <= 1'b0;
         adr_q <= 32'h0;
         cnt_q <= 16'h0000;
         ovf_ie_q <= 1'b0;
         ch_ie_q <= 1'b0;
      end else begin
         wr_q <= hsel && hready && htrans[1] && hwrite;
         adr_q <= haddr;
         cnt_q <= cnt_value;
         if (wr_q && adr_q == 32'h0) begin
            ovf_ie_q <= hwdata[0];
         end
         if (wr_q && adr_q == 32'h10) begin
            ch_ie_q <= hwdata[4];
         end
      end
   end

   // ---------------------------------------------
   // properties
   // ---------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   a_reset_irq_quiet: assert property ($fell(rst) |-> !overflow_irq && !channel_irq[0])
      else $error("request pending after reset");
   a_reset_ctrl_clear: assert property ($fell(rst) |-> !center_align_select)
      else $error("control not cleared by reset");
   a_ovf_irq_level: assert property (overflow_irq |-> ovf_ie_q)
      else $error("overflow request without enable");
   a_ch_irq_level: assert property (channel_irq[0] |-> ch_ie_q)
      else $error("channel request without enable");
   a_ovf_hold_set: assert property (overflow_irq && !(wr_q && adr_q == 32'h0) |=> overflow_irq)
      else $error("overflow request dropped without a write");
   a_ch_hold_set: assert property (channel_irq[0] && !(wr_q && adr_q == 32'h10) |=> channel_irq[0])
      else $error("channel request dropped without a write");
   a_ovf_wrap_sets: assert property (ovf_ev && ovf_ie_q && !wr_q |=> overflow_irq)
      else $error("wrap did not raise overflow request");
   a_ovf_rise_cause: assert property ($rose(overflow_irq) |->
      $past(wr_q) || $past(ovf_ev) || (center_align_select && $past(cnt_down)))
      else $error("overflow request rose without cause");
endmodule

bind timer_pwm_event_flags timer_flags_chk #(.NUM_CH(NUM_CH)) u_chk (
   .core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .cnt_value(cnt_value),
   .cnt_down(cnt_down), .center_align_select(center_align_select),
   .modulo_value(modulo_value), .overflow_irq(overflow_irq), .channel_irq(channel_irq));

`default_nettype wire

/* File: testbench/timer_pwm_event_flags_bench.sv */
// self-checking bench for the timer event-flag block
`timescale 1ns/1ps
`default_nettype none

module timer_pwm_event_flags_bench;
   logic core_clk, rst, hsel, hwrite, cnt_down;
   logic [31:0] haddr, hwdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [15:0] cnt_value;
   logic [0:0] capture_in;
   wire logic hreadyout, hresp, center_align_select, overflow_irq;
   wire logic [31:0] hrdata;
   wire logic [15:0] modulo_value;
   wire logic [0:0] channel_irq;
   integer bad_count = 0;
   integer n_tests = 0;

   timer_pwm_event_flags #(.NUM_CH(1)) u_dut (
      .core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cnt_value(cnt_value),
      .cnt_down(cnt_down), .capture_in(capture_in),
      .center_align_select(center_align_select), .modulo_value(modulo_value),
      .overflow_irq(overflow_irq), .channel_irq(channel_irq));

   // ---------------------------------------------
   // shared tasks
   // ---------------------------------------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic print_verdict;
      if (bad_count == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // one single transfer; entered just after a rising edge
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= wr;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wr ? d : 32'h0;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic ticks(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic cnt(input logic [15:0] v);
      @(posedge core_clk);
      cnt_value <= v;
   endtask
   task automatic clear(input logic [31:0] a, input logic [31:0] cfg);
      bus(1'b0, a, 32'h0);
      bus(1'b1, a, cfg);
   endtask

   // ---------------------------------------------
   // scenarios
   // ---------------------------------------------
   task automatic t_reset;
      check("ovf_irq", overflow_irq, 0);
      check("ch_irq", channel_irq, 0);
      check("center rst", center_align_select, 0);
      check("modulo rst", modulo_value, 0);
      check("hresp", hresp, 0);
      check("hreadyout", hreadyout, 1);
      bus(1'b0, 32'h0, 0);
      check("status", rd, 0);
      bus(1'b0, 32'h10, 0);
      check("ch_ctrl", rd, 0);
   endtask
   task automatic t_ovf_edge;
      bus(1'b1, 32'h4, 32'h5);
      bus(1'b1, 32'h0, 32'h1);
      check("modulo out", modulo_value, 16'h5);
      cnt(16'h4);
      cnt(16'h0);
      ticks(2);
      check("no wrap", overflow_irq, 0);
      cnt(16'h5);
      cnt(16'h0);
      ticks(2);
      check("wrap", overflow_irq, 1);
      bus(1'b1, 32'h0, 32'h1);
      ticks(1);
      check("write only", overflow_irq, 1);
      bus(1'b0, 32'h0, 0);
      check("poll", rd[7], 1);
      bus(1'b1, 32'h0, 32'h1);
      ticks(1);
      check("cleared", overflow_irq, 0);
      bus(1'b1, 32'h4, 32'h0);
      cnt(16'hffff);
      cnt(16'h0);
      ticks(2);
      check("free wrap", overflow_irq, 1);
      bus(1'b0, 32'h0, 0);
      cnt(16'hffff);
      cnt(16'h0);
      bus(1'b1, 32'h0, 32'h1);
      ticks(1);
      check("race", overflow_irq, 1);
      bus(1'b1, 32'h0, 32'h0);
      ticks(1);
      check("masked", overflow_irq, 0);
      bus(1'b0, 32'h0, 0);
      check("masked poll", rd[7], 1);
      clear(32'h0, 32'h0);
   endtask
   task automatic t_center;
      bus(1'b1, 32'h4, 32'h5);
      bus(1'b1, 32'h0, 32'h3);
      bus(1'b1, 32'h14, 32'h3);
      bus(1'b1, 32'h10, 32'h10);
      check("center out", center_align_select, 1);
      cnt(16'h2);
      cnt(16'h3);
      ticks(2);
      check("cpwm up", channel_irq, 1);
      clear(32'h10, 32'h10);
      cnt(16'h4);
      cnt(16'h5);
      ticks(2);
      check("no turn", overflow_irq, 0);
      @(posedge core_clk);
      cnt_down <= 1'b1;
      cnt_value <= 16'h4;
      ticks(2);
      check("turn", overflow_irq, 1);
      cnt(16'h3);
      ticks(2);
      check("cpwm down", channel_irq, 1);
      clear(32'h10, 32'h10);
      clear(32'h0, 32'h0);
      cnt_down <= 1'b0;
   endtask
   task automatic t_match;
      logic [31:0] cfg;
      for (int m = 0; m < 2; m++) begin
         cfg = m ? 32'h18 : 32'h14;
         bus(1'b1, 32'h10, cfg);
         bus(1'b1, 32'h14, 32'h7);
         bus(1'b0, 32'h14, 0);
         check("ch value", rd, 32'h7);
         bus(1'b0, 32'h8, 0);
         check("count", rd, {16'h0, cnt_value});
         for (int k = 0; k < 2; k++) begin
            cnt(16'h6 + 16'(2 * k));
            ticks(2);
            check("no match", channel_irq, 0);
            cnt(16'h7);
            ticks(2);
            check("match", channel_irq, 1);
            clear(32'h10, cfg);
            ticks(1);
            check("match clr", channel_irq, 0);
         end
      end
   endtask
   task automatic t_capture;
      for (int e = 0; e < 4; e++) begin
         bus(1'b1, 32'h10, 32'h10 | e);
         capture_in <= 1'b1;
         ticks(6);
         check("rise", channel_irq, e & 1);
         clear(32'h10, 32'h10 | e);
         capture_in <= 1'b0;
         ticks(6);
         check("fall", channel_irq, (e >> 1) & 1);
         clear(32'h10, 32'h10 | e);
      end
   endtask

   // ---------------------------------------------
   // clock, watchdog and main sequence
   // ---------------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   initial begin
      #(25 * 5000);
      bad_count++;
      print_verdict;
   end
   initial begin
      rst = 1'b1;
      hsel = 1'b1;
      hsize = 3'b010;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hwdata = 32'h0;
      cnt_value = 16'h0;
      cnt_down = 1'b0;
      capture_in = 1'b0;
      ticks(12);
      rst <= 1'b0;
      ticks(1);
      t_reset;
      t_ovf_edge;
      t_center;
      t_match;
      t_capture;
      print_verdict;
   end
endmodule

`default_nettype wire
